// ### ercd_partner.sv
// Far-side model: system reset controller and PCS link status source.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module ercd_partner
    import ercd_pkg::*;
(
    // Clock
    input  wire logic clock_in,
    // Reset pins and link status
    output logic      tx_rst_n_out,
    output logic      rx_rst_n_out,
    output logic      csr_rst_n_out,
    output logic      sync_hdr_ok_out,
    output logic      tx_lanes_ok_out
);
    // ****************************************************************
    // Reset controller
    // ****************************************************************
    // Power-up: every reset low for the minimum hold, link healthy
    initial begin
        {tx_rst_n_out, rx_rst_n_out, csr_rst_n_out} = 3'b000;
        {sync_hdr_ok_out, tx_lanes_ok_out} = 2'b11;
        repeat (RST_MIN_CYCLES) @(posedge clock_in);
        #1 {tx_rst_n_out, rx_rst_n_out, csr_rst_n_out} = 3'b111;
    end

    // Short holds are stretched, as a real controller must
    task automatic pulse_reset(input int which, input int len);
        int n;
        n = (len < RST_MIN_CYCLES) ? RST_MIN_CYCLES : len;
        case (which)
            0: tx_rst_n_out = 1'b0;
            1: rx_rst_n_out = 1'b0;
            default: csr_rst_n_out = 1'b0;
        endcase
        repeat (n) @(posedge clock_in);
        #1 {tx_rst_n_out, rx_rst_n_out, csr_rst_n_out} = 3'b111;
    endtask

    // Transmit lanes drop out for a while, then recover
    task automatic lanes_drop(input int len);
        tx_lanes_ok_out = 1'b0;
        repeat (len) @(posedge clock_in);
        #1 tx_lanes_ok_out = 1'b1;
    endtask

    // One missing sync header breaks the run of good ones
    task automatic header_glitch();
        sync_hdr_ok_out = 1'b0;
        @(posedge clock_in);
        #1 sync_hdr_ok_out = 1'b1;
    endtask
endmodule // ercd_partner

// ### ercd_pkg.sv
// Package for the Ethernet reset sequencer and register-space decoder.
// Assumes a single 50 MHz clock and word-addressed 32-bit management accesses.
package ercd_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 20;
    localparam int unsigned SYNC_STAGES       = 2;
    localparam int unsigned RST_MIN_CYCLES    = 10;
    localparam int unsigned LOCK_CYCLES       = 64;
    localparam int unsigned INIT_CYCLES       = 8;

    // ****************************************************************
    // Word-offset region bounds
    // ****************************************************************
    localparam logic [11:0] PHY_LO   = 12'h300;
    localparam logic [11:0] PHY_HI   = 12'h3ff;
    localparam logic [11:0] TXM_LO   = 12'h400;
    localparam logic [11:0] TXM_HI   = 12'h4ff;
    localparam logic [11:0] RXM_LO   = 12'h500;
    localparam logic [11:0] RXM_HI   = 12'h5ff;
    localparam logic [11:0] FC_LO    = 12'h600;
    localparam logic [11:0] FC_HI    = 12'h708;
    localparam logic [11:0] TXS_LO   = 12'h800;
    localparam logic [11:0] TXS_HI   = 12'h8ff;
    localparam logic [11:0] RXS_LO   = 12'h900;
    localparam logic [11:0] RXS_HI   = 12'h9ff;
    localparam logic [11:0] TXT_LO   = 12'ha00;
    localparam logic [11:0] TXT_HI   = 12'haff;
    localparam logic [11:0] RXT_LO   = 12'hb00;
    localparam logic [11:0] RXT_HI   = 12'hbff;
    localparam logic [11:0] TXF_LO   = 12'hc00;
    localparam logic [11:0] TXF_HI   = 12'hcff;
    localparam logic [11:0] RXF_LO   = 12'hd00;
    localparam logic [11:0] RXF_HI   = 12'hdff;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ERCD_REG_NONE = 4'h0,
        ERCD_REG_PHY  = 4'h1,
        ERCD_REG_TXM  = 4'h2,
        ERCD_REG_RXM  = 4'h3,
        ERCD_REG_FC   = 4'h4,
        ERCD_REG_TXS  = 4'h5,
        ERCD_REG_RXS  = 4'h6,
        ERCD_REG_TXT  = 4'h7,
        ERCD_REG_RXT  = 4'h8,
        ERCD_REG_TXF  = 4'h9,
        ERCD_REG_RXF  = 4'ha
    } ercd_region_t;

    typedef enum logic [1:0] {
        ERCD_PATH_RESET = 2'b00,
        ERCD_PATH_INIT  = 2'b01,
        ERCD_PATH_READY = 2'b10
    } ercd_path_state_t;

    // Per-path domain resets handed to the datapath
    typedef struct packed {
        logic tx_n;
        logic rx_n;
        logic csr_n;
        logic phy_n;
    } ercd_resets_t;

    // Decoded management access
    typedef struct packed {
        ercd_region_t region;
        logic         write;
        logic         read;
    } ercd_sel_t;

endpackage : ercd_pkg

// ### ercd_top.sv
// Reset synchroniser, readiness sequencing and register-space decoder.
// Assumes the reset pins are asynchronous and the management master sends
// word addresses with whole 32-bit accesses only.
//
// Notes on behaviour
// - Three async active-low resets, each synchronised inside before use.
// - Global reset returns all control and status registers to initial values.
// - Both readiness outputs rise after a successful exit from reset.
// - Transmit reset clears transmit path and lowers lanes-stable.
// - Receive reset clears receive path and lowers receive-ready.
// - Global reset clears everything and lowers both readiness outputs.
// - Register space is word addressed, 32 bits, no byte access.
// - Writes to read-only fields change nothing.
// - Reserved reads return an unspecified value.
// - Writes to reserved registers do not affect state.
// - Absent registers and undefined bits are reserved.
// - PHY, TX MAC, RX MAC and flow-control regions decoded.
// - Statistics, timestamp and FEC regions decoded.
// - PHY registers cleared only by the global reset.
// - Receive-ready follows block lock, 65 consecutive sync headers.
`timescale 1ns/1ps

module ercd_top
    import ercd_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset pins
    input  wire logic              clock_in,
    input  wire logic              tx_rst_n_in,
    input  wire logic              rx_rst_n_in,
    input  wire logic              csr_rst_n_in,
    // Link status from the PCS
    input  wire logic              sync_hdr_ok_in,
    input  wire logic              tx_lanes_ok_in,
    // Management access
    input  wire logic [ADDR_W-1:0] mgmt_addr_in,
    input  wire logic              mgmt_read_in,
    input  wire logic              mgmt_write_in,
    // Domain resets and decode
    output ercd_resets_t           resets_out,
    output ercd_sel_t              sel_out,
    // Readiness
    output logic                   rx_ready_out,
    output logic                   tx_stable_out,
    output logic                   block_lock_out
);

    // ****************************************************************
    // Reset synchronisers
    // ****************************************************************
    logic [SYNC_STAGES-1:0] tx_sync_q, tx_sync_d;
    logic [SYNC_STAGES-1:0] rx_sync_q, rx_sync_d;
    logic [SYNC_STAGES-1:0] csr_sync_q, csr_sync_d;
    logic tx_rst, rx_rst, csr_rst;

    // Two-stage shift; only the last stage is read
    always_comb begin
        tx_sync_d  = {tx_sync_q[SYNC_STAGES-2:0], tx_rst_n_in};
        rx_sync_d  = {rx_sync_q[SYNC_STAGES-2:0], rx_rst_n_in};
        csr_sync_d = {csr_sync_q[SYNC_STAGES-2:0], csr_rst_n_in};
    end

    // Clocked by clock_in with no reset; the board reset only feeds these stages
    always_ff @(posedge clock_in) begin
        tx_sync_q  <= tx_sync_d;
        rx_sync_q  <= rx_sync_d;
        csr_sync_q <= csr_sync_d;
    end

    // Global reset overrides both path resets
    assign csr_rst = ~csr_sync_q[SYNC_STAGES-1];
    assign tx_rst  = csr_rst | ~tx_sync_q[SYNC_STAGES-1];
    assign rx_rst  = csr_rst | ~rx_sync_q[SYNC_STAGES-1];

    // Domain resets: PHY space only sees the global one
    always_comb begin
        resets_out.tx_n  = ~tx_rst;
        resets_out.rx_n  = ~rx_rst;
        resets_out.csr_n = ~csr_rst;
        resets_out.phy_n = ~csr_rst;
    end

    // ****************************************************************
    // Block lock from consecutive sync headers
    // ****************************************************************
    logic [1:0] hdr_s_q, hdr_s_d;
    logic [6:0] lock_cnt_q, lock_cnt_d;
    logic       lock_q, lock_d;

    // Any bad header restarts the run; lock drops with it
    always_comb begin
        hdr_s_d    = {hdr_s_q[0], sync_hdr_ok_in};
        lock_cnt_d = lock_cnt_q;
        lock_d     = lock_q;
        // Unknown reset state after power-up falls into the clearing branch
        if (!rx_rst && hdr_s_q[1]) begin
            if (lock_cnt_q < 7'(LOCK_CYCLES)) begin
                lock_cnt_d = lock_cnt_q + 7'h01;
            end else begin
                lock_d = 1'b1;
            end
        end else begin
            lock_cnt_d = 7'h00;
            lock_d     = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        hdr_s_q    <= hdr_s_d;
        lock_cnt_q <= lock_cnt_d;
        lock_q     <= lock_d;
    end

    assign block_lock_out = lock_q;

    // ****************************************************************
    // Transmit path sequencer
    // ****************************************************************
    ercd_path_state_t tx_st_q, tx_st_d;
    logic [3:0]       tx_cnt_q, tx_cnt_d;
    logic [1:0]       lanes_s_q, lanes_s_d;
    logic             tx_stable_q, tx_stable_d;

    // Re-initialise for a fixed time, then report stable lanes
    always_comb begin
        lanes_s_d   = {lanes_s_q[0], tx_lanes_ok_in};
        tx_st_d     = tx_st_q;
        tx_cnt_d    = tx_cnt_q;
        tx_stable_d = 1'b0;
        // Unknown reset state after power-up falls into the reset branch
        if (!tx_rst) begin
            case (tx_st_q)
                ERCD_PATH_RESET: begin
                    tx_st_d = ERCD_PATH_INIT;
                end
                ERCD_PATH_INIT: begin
                    tx_cnt_d = tx_cnt_q + 4'h1;
                    if (tx_cnt_q == 4'(INIT_CYCLES - 1)) begin
                        tx_st_d = ERCD_PATH_READY;
                    end
                end
                ERCD_PATH_READY: begin
                    tx_stable_d = lanes_s_q[1];
                end
                default: begin
                    tx_st_d = ERCD_PATH_RESET;
                end
            endcase
        end else begin
            tx_st_d  = ERCD_PATH_RESET;
            tx_cnt_d = 4'h0;
        end
    end

    always_ff @(posedge clock_in) begin
        lanes_s_q   <= lanes_s_d;
        tx_st_q     <= tx_st_d;
        tx_cnt_q    <= tx_cnt_d;
        tx_stable_q <= tx_stable_d;
    end

    assign tx_stable_out = tx_stable_q;

    // ****************************************************************
    // Receive path sequencer
    // ****************************************************************
    ercd_path_state_t rx_st_q, rx_st_d;
    logic [3:0]       rx_cnt_q, rx_cnt_d;
    logic             rx_ready_q, rx_ready_d;

    // Ready only after re-init and while block lock holds
    always_comb begin
        rx_st_d    = rx_st_q;
        rx_cnt_d   = rx_cnt_q;
        rx_ready_d = 1'b0;
        if (!rx_rst) begin
            case (rx_st_q)
                ERCD_PATH_RESET: begin
                    rx_st_d = ERCD_PATH_INIT;
                end
                ERCD_PATH_INIT: begin
                    rx_cnt_d = rx_cnt_q + 4'h1;
                    if (rx_cnt_q == 4'(INIT_CYCLES - 1)) begin
                        rx_st_d = ERCD_PATH_READY;
                    end
                end
                ERCD_PATH_READY: begin
                    rx_ready_d = lock_q;
                end
                default: begin
                    rx_st_d = ERCD_PATH_RESET;
                end
            endcase
        end else begin
            rx_st_d  = ERCD_PATH_RESET;
            rx_cnt_d = 4'h0;
        end
    end

    always_ff @(posedge clock_in) begin
        rx_st_q    <= rx_st_d;
        rx_cnt_q   <= rx_cnt_d;
        rx_ready_q <= rx_ready_d;
    end

    assign rx_ready_out = rx_ready_q;

    // ****************************************************************
    // Register-space decoder
    // ****************************************************************
    // Unmapped words decode to no region, so writes there touch nothing
    ercd_region_t region;
    logic [11:0]  waddr;

    assign waddr = 12'(mgmt_addr_in);

    always_comb begin
        region = ERCD_REG_NONE;
        if      (waddr >= PHY_LO && waddr <= PHY_HI) region = ERCD_REG_PHY;
        else if (waddr >= TXM_LO && waddr <= TXM_HI) region = ERCD_REG_TXM;
        else if (waddr >= RXM_LO && waddr <= RXM_HI) region = ERCD_REG_RXM;
        else if (waddr >= FC_LO  && waddr <= FC_HI)  region = ERCD_REG_FC;
        else if (waddr >= TXS_LO && waddr <= TXS_HI) region = ERCD_REG_TXS;
        else if (waddr >= RXS_LO && waddr <= RXS_HI) region = ERCD_REG_RXS;
        else if (waddr >= TXT_LO && waddr <= TXT_HI) region = ERCD_REG_TXT;
        else if (waddr >= RXT_LO && waddr <= RXT_HI) region = ERCD_REG_RXT;
        else if (waddr >= TXF_LO && waddr <= TXF_HI) region = ERCD_REG_TXF;
        else if (waddr >= RXF_LO && waddr <= RXF_HI) region = ERCD_REG_RXF;
    end

    // Strobes suppressed in global reset or for unmapped words
    always_comb begin
        sel_out.region = region;
        sel_out.write  = mgmt_write_in && !csr_rst && region != ERCD_REG_NONE;
        sel_out.read   = mgmt_read_in && !csr_rst && region != ERCD_REG_NONE;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_tx_low_reset: assert property (@(posedge clock_in)
        tx_rst |=> !tx_stable_out) else $error("lanes stable during tx reset");
    a_rx_low_reset: assert property (@(posedge clock_in)
        rx_rst |=> !rx_ready_out) else $error("rx ready during rx reset");
    a_both_low_global: assert property (@(posedge clock_in)
        csr_rst |=> !rx_ready_out && !tx_stable_out) else $error("ready in global reset");
    a_ready_needs_lock: assert property (@(posedge clock_in)
        rx_ready_out |-> $past(lock_q)) else $error("rx ready without lock");
    a_lock_after_run: assert property (@(posedge clock_in)
        $rose(lock_q) |-> $past(lock_cnt_q) == 7'(LOCK_CYCLES)) else $error("lock early");
    a_init_delay_tx: assert property (@(posedge clock_in)
        $fell(tx_rst) |-> !tx_stable_out [*8]) else $error("tx ready too soon");
    a_init_delay_rx: assert property (@(posedge clock_in)
        $fell(rx_rst) |-> !rx_ready_out [*8]) else $error("rx ready too soon");
    a_phy_global_only: assert property (@(posedge clock_in)
        $past(csr_rst_n_in, 2) |-> resets_out.phy_n) else $error("phy reset not global");
    a_no_unmapped_wr: assert property (@(posedge clock_in)
        mgmt_write_in && region == ERCD_REG_NONE |-> !sel_out.write) else $error("unmapped write");
    a_fc_top_edge: assert property (@(posedge clock_in)
        waddr == 12'h709 |-> region == ERCD_REG_NONE) else $error("fc range too wide");

endmodule // ercd_top

// ### testbench.sv
// Self-checking bench for the reset sequencer and register decoder.
// Assumes ercd_top and ercd_partner are compiled first.
`timescale 1ns/1ps

module testbench
    import ercd_pkg::*;
;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    typedef struct packed {
        ercd_sel_t sel;
        logic      only;
    } ercd_note_t;
    logic         clock_in;
    logic         tx_rst_n, rx_rst_n, csr_rst_n, hdr_ok, lanes_ok;
    logic [11:0]  mgmt_addr_in;
    logic         mgmt_read_in, mgmt_write_in;
    ercd_resets_t resets_out;
    ercd_sel_t    sel_out;
    logic         rx_ready_out, tx_stable_out, block_lock_out;
    ercd_note_t   notes[$];
    int           bad_count, checked;
    logic [15:0]  s;
    logic [11:0]  addrs[25] = '{12'h300, 12'h3ff, 12'h400, 12'h4ff, 12'h500, 12'h5ff,
        12'h600, 12'h708, 12'h800, 12'h8ff, 12'h900, 12'h9ff, 12'ha00, 12'haff, 12'hb00,
        12'hbff, 12'hc00, 12'hcff, 12'hd00, 12'hdff, 12'h2ff, 12'h709, 12'h7ff, 12'he00, 12'h000};

    ercd_top i_ercd_top (.clock_in(clock_in), .tx_rst_n_in(tx_rst_n), .rx_rst_n_in(rx_rst_n),
        .csr_rst_n_in(csr_rst_n), .sync_hdr_ok_in(hdr_ok), .tx_lanes_ok_in(lanes_ok),
        .mgmt_addr_in(mgmt_addr_in), .mgmt_read_in(mgmt_read_in),
        .mgmt_write_in(mgmt_write_in), .resets_out(resets_out), .sel_out(sel_out),
        .rx_ready_out(rx_ready_out), .tx_stable_out(tx_stable_out),
        .block_lock_out(block_lock_out));
    ercd_partner i_ercd_partner (.clock_in(clock_in), .tx_rst_n_out(tx_rst_n),
        .rx_rst_n_out(rx_rst_n), .csr_rst_n_out(csr_rst_n), .sync_hdr_ok_out(hdr_ok),
        .tx_lanes_ok_out(lanes_ok));

    // 50 MHz clock
    initial clock_in = 1'b0;
    always #10 clock_in = ~clock_in;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Region worked out from the page number of the word offset
    function automatic ercd_region_t exp_region(input logic [11:0] a);
        case (a[11:8])
            4'h3, 4'h4, 4'h5: return ercd_region_t'(a[11:8] - 4'h2);
            4'h6: return ERCD_REG_FC;
            4'h7: return (a <= 12'h708) ? ERCD_REG_FC : ERCD_REG_NONE;
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: return ercd_region_t'(a[11:8] - 4'h3);
            default: return ERCD_REG_NONE;
        endcase
    endfunction

    // One full-word access; only marks a strobe check during global reset
    task automatic access(input logic [11:0] a, input logic wr, input logic only);
        ercd_note_t n;
        @(posedge clock_in);
        #1;
        mgmt_addr_in = a;
        mgmt_write_in = wr;
        mgmt_read_in = !wr;
        n.sel.region = only ? ERCD_REG_NONE : exp_region(a);
        n.sel.write = wr && !only && n.sel.region != ERCD_REG_NONE;
        n.sel.read = !wr && !only && n.sel.region != ERCD_REG_NONE;
        n.only = only;
        notes.push_back(n);
    endtask

    task automatic idle();
        @(posedge clock_in);
        #1 {mgmt_read_in, mgmt_write_in} = 2'b00;
    endtask

    // Bounded wait for both readiness outputs
    task automatic wait_ready();
        for (int n = 0; n < 200 && !(rx_ready_out === 1'b1 && tx_stable_out === 1'b1); n++) begin
            @(posedge clock_in);
            #1;
        end
    endtask

    // ****************************************************************
    // Monitor and watchdog
    // ****************************************************************
    // Every strobe cycle consumes the oldest note
    always @(posedge clock_in) begin
        if (mgmt_read_in || mgmt_write_in) begin
            if (notes.size() == 0) check("note", 8'h1, 8'h0);
            else if (notes[0].only) check("strobes", {6'h0, sel_out.write, sel_out.read},
                {6'h0, notes[0].sel.write, notes[0].sel.read});
            else check("decode", {2'h0, sel_out}, {2'h0, notes[0].sel});
            if (notes.size() != 0) void'(notes.pop_front());
        end
    end

    // Run needs about 600 cycles
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {mgmt_read_in, mgmt_write_in, mgmt_addr_in} = 14'h0;
        repeat (4) @(posedge clock_in);
        access(12'h400, 1'b1, 1'b1); // no strobe while global reset active
        idle();
        wait_ready();
        check("ready", {6'h0, rx_ready_out, tx_stable_out}, 8'h3);
        check("resets", {4'h0, resets_out}, 8'hf);
        // Every region edge and the gaps beside them, both directions
        foreach (addrs[i]) begin
            access(addrs[i], 1'b1, 1'b0);
            access(addrs[i], 1'b0, 1'b0);
        end
        s = 16'h0018;
        repeat (150) begin
            s = lfsr(s);
            access(s[11:0], s[12], 1'b0);
        end
        idle();
        // Transmit, receive and global reset in turn
        for (int w = 0; w < 3; w++) begin
            fork
                i_ercd_partner.pulse_reset(w, 10);
                begin
                    repeat (4) @(posedge clock_in);
                    #1;
                    check("resets", {4'h0, resets_out}, {4'h0, w == 1 ? 1'b1 : 1'b0,
                        w == 0 ? 1'b1 : 1'b0, w != 2, w != 2});
                    check("tx_stable", {7'h0, tx_stable_out}, {7'h0, w == 1});
                    check("rx_ready", {7'h0, rx_ready_out}, {7'h0, w == 0});
                end
            join
            repeat (5) @(posedge clock_in);
            #1;
            check("ready early", {6'h0, rx_ready_out, tx_stable_out},
                {6'h0, w == 0, w == 1});
            wait_ready();
            check("ready", {6'h0, rx_ready_out, tx_stable_out}, 8'h3);
        end
        // Lock lost on one bad header and regained after the full run
        i_ercd_partner.header_glitch();
        repeat (5) @(posedge clock_in);
        #1;
        check("lock lost", {6'h0, block_lock_out, rx_ready_out}, 8'h0);
        repeat (50) @(posedge clock_in);
        #1;
        check("lock early", {7'h0, block_lock_out}, 8'h0);
        for (int n = 0; n < 40 && block_lock_out !== 1'b1; n++) begin
            @(posedge clock_in);
            #1;
        end
        repeat (3) @(posedge clock_in);
        #1;
        check("relock", {6'h0, block_lock_out, rx_ready_out}, 8'h3);
        // Lanes drop for a while: stable follows them down and back up
        fork
            i_ercd_partner.lanes_drop(6);
            begin
                repeat (4) @(posedge clock_in);
                #1;
                check("lanes down", {7'h0, tx_stable_out}, 8'h0);
            end
        join
        repeat (5) @(posedge clock_in);
        #1;
        check("lanes back", {7'h0, tx_stable_out}, 8'h1);
        check("notes left", 8'(notes.size()), 8'h0);
        give_verdict();
    end
endmodule // testbench
